// *** rtl/seepb_pkg.sv ***
// seepb_pkg: shared constants and types of the two-wire EEPROM protocol layer
// assumes both ends run on one 25 MHz system clock
package seepb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // internal program time, in microseconds, and its cycle count (longest time rounds down)
  localparam int unsigned INTERNAL_PROGRAM_TIME_US = 5000;
  localparam int unsigned PROG_CYCLES = (INTERNAL_PROGRAM_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W = 18;
  // word framing
  localparam int unsigned WORD_BITS = 8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // host serial clock divider: half period in system cycles (5 us high / low)
  localparam int unsigned HALF_SCL_NS = 5000;
  localparam int unsigned HALF_SCL_CYCLES = HALF_SCL_NS / CLK_PERIOD_NS;
  localparam logic [7:0] HALF_SCL_CNT = 8'(HALF_SCL_CYCLES);
  localparam logic [7:0] QUART_SCL_CNT = 8'(HALF_SCL_CYCLES / 2);
  // recovery clock count
  localparam logic [3:0] RECOVER_CLOCKS = 4'h9;
  // fifo
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 16;
  // host commands
  typedef enum logic [2:0] {
    SEEPB_CMD_START,
    SEEPB_CMD_WRITE,
    SEEPB_CMD_READ_ACK,
    SEEPB_CMD_READ_NACK,
    SEEPB_CMD_STOP,
    SEEPB_CMD_RECOVER
  } seepb_cmd_t;
endpackage : seepb_pkg

// *** rtl/seepb_if.sv ***
// seepb_if: the two-wire bus between the bus controller and the eeprom target
// assumes the open-drain wires are resolved here from the enables (low enable pulls low)
interface seepb_if;
  logic scl_out_host;
  logic scl_oe_n_host;
  logic sda_out_host;
  logic sda_oe_n_host;
  logic sda_out_dev;
  logic sda_oe_n_dev;
  logic scl;
  logic sda;
  // open-drain resolution, pulled high when nobody pulls low
  assign scl = scl_oe_n_host ? 1'b1 : scl_out_host;
  assign sda = (sda_oe_n_host ? 1'b1 : sda_out_host) & (sda_oe_n_dev ? 1'b1 : sda_out_dev);
  modport host (output scl_out_host, output scl_oe_n_host, output sda_out_host,
                output sda_oe_n_host, input scl, input sda);
  modport dev (output sda_out_dev, output sda_oe_n_dev, input scl, input sda);
endinterface : seepb_if

// *** rtl/seepb_fifo.sv ***
// seepb_fifo: flip-flop fifo with valid/ready on both sides
// assumes a single clock domain; width and depth shape the storage
module seepb_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // write side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire push = wr_valid_in & wr_ready_out;
  wire pop = rd_valid_out & rd_ready_in;

  // honest flags straight from the count
  assign wr_ready_out = (count_q != (AW + 1)'(DEPTH));
  assign rd_valid_out = (count_q != '0);
  assign rd_data_out = mem_q[rd_ptr_q];

  // pointers and count
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (clk_en_in) begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // storage, one entry per index
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk_sys_in) begin
      if (clk_en_in && push && (wr_ptr_q == AW'(i))) mem_q[i] <= wr_data_in;
    end
  end
endmodule : seepb_fifo

// *** rtl/seepb_dev.sv ***
// seepb_dev: protocol layer of the two-wire eeprom target
// assumes scl and sda arrive asynchronously; the system clock is much faster than scl
// received words leave through a 16-word fifo; memory logic feeds tx bytes and ack decisions

// Overview of operation
// - data changes only while clock low
// - sda fall with scl high starts transfer
// - controller starts first; else bus ignored
// - sda rise with scl high stops transfer
// - stop after read returns to standby
// - every item is an eight-bit word
// - pull sda low on ninth clock
// - controller acks, then continues or stops
// - standby at reset and after stop (after a write the code enters standby only once the write cycle ends)
// - controller recovery: nine clocks then start (the host's recover command stops early once sda reads high)
// - write cycle ends within five milliseconds
// - sample on rise, shift after fall
// - only pull sda low or release
// - first word bit eight selects direction
// - ignore bus during internal write cycle
module seepb_dev #(
  parameter int unsigned PROG_CYCLES_P = seepb_pkg::PROG_CYCLES
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // bus pins
  seepb_if.dev bus,
  // received words, fifo output
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // word to send in a read, and whether to ack non-first written words
  input wire logic [7:0] tx_data_in,
  input wire logic ack_en_in,
  // status
  output logic standby_out,
  output logic busy_out,
  output logic read_mode_out,
  output logic start_out,
  output logic stop_out,
  output logic tx_req_out,
  output logic overflow_out
);
  import seepb_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_PROG
  } seepb_dev_st_t;

  seepb_dev_st_t st_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic first_q;
  logic wrote_q;
  logic sda_pull_q;
  logic standby_q, busy_q, read_q, start_q, stop_q, txreq_q, ovf_q;
  logic [PROG_CNT_W-1:0] prog_cnt_q;
  logic fifo_ready;
  logic room_q;
  logic push_q;
  logic [7:0] push_data_q;

  // edge and condition decode, from synchronised copies only
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_cond = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  wire prog_done = (prog_cnt_q == PROG_CNT_W'(PROG_CYCLES_P - 1));
  wire word_done = scl_rise & (bit_cnt_q == 4'(WORD_BITS - 1));
  wire [7:0] word_in = {shift_q[6:0], sda_s2_q};
  wire dir_read = first_q & sda_s2_q;
  wire do_ack = first_q | ack_en_in;

  // two-flop synchronisers plus a third stage for edges
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else if (clk_en_in) begin
      scl_s1_q <= bus.scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // protocol state machine
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= ST_IDLE;
      bit_cnt_q <= BIT_CNT_RST;
      shift_q <= BYTE_RST;
      first_q <= 1'b0;
      wrote_q <= 1'b0;
      sda_pull_q <= 1'b0;
      standby_q <= 1'b1;
      busy_q <= 1'b0;
      read_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      txreq_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= BYTE_RST;
      room_q <= 1'b0;
      prog_cnt_q <= '0;
    end else if (clk_en_in) begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
      txreq_q <= 1'b0;
      push_q <= 1'b0;
      if (st_q == ST_PROG) begin
        // inputs ignored while programming; no ack possible
        sda_pull_q <= 1'b0;
        prog_cnt_q <= prog_cnt_q + 1'b1;
        if (prog_done) begin
          st_q <= ST_IDLE;
          busy_q <= 1'b0;
          standby_q <= 1'b1;
        end
      end else if (start_cond) begin
        // start at any point outside the write cycle, even mid-word, reframes from bit one
        st_q <= ST_RECV;
        bit_cnt_q <= BIT_CNT_RST;
        first_q <= 1'b1;
        wrote_q <= 1'b0;
        sda_pull_q <= 1'b0;
        standby_q <= 1'b0;
        start_q <= 1'b1;
      end else if (stop_cond && st_q != ST_IDLE) begin
        stop_q <= 1'b1;
        sda_pull_q <= 1'b0;
        if (wrote_q) begin
          st_q <= ST_PROG;
          busy_q <= 1'b1;
          prog_cnt_q <= '0;
        end else begin
          st_q <= ST_IDLE;
          standby_q <= 1'b1;
        end
      end else begin
        // idle ignores everything but a start
        case (st_q)
          ST_RECV: begin
            if (scl_rise) begin
              shift_q <= word_in;
              bit_cnt_q <= bit_cnt_q + 1'b1;
              if (word_done) begin
                st_q <= ST_ACK;
                push_q <= 1'b1;
                push_data_q <= word_in;
                // room judged before the push, so the word that fills the fifo is still acked
                room_q <= fifo_ready;
                if (first_q) read_q <= dir_read;
                if (!first_q) wrote_q <= ~read_q;
              end
            end
          end
          ST_ACK: begin
            // ack driven from the fall after bit eight, released after the ninth clock
            if (scl_fall && bit_cnt_q == ACK_BIT) begin
              sda_pull_q <= do_ack & room_q;
              bit_cnt_q <= bit_cnt_q + 1'b1;
            end else if (scl_fall) begin
              sda_pull_q <= 1'b0;
              bit_cnt_q <= BIT_CNT_RST;
              first_q <= 1'b0;
              if (read_q) begin
                st_q <= ST_SEND;
                shift_q <= tx_data_in;
                sda_pull_q <= ~tx_data_in[7];
                txreq_q <= 1'b1;
              end else begin
                st_q <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              bit_cnt_q <= bit_cnt_q + 1'b1;
              if (bit_cnt_q == 4'(WORD_BITS - 1)) begin
                st_q <= ST_MACK;
                sda_pull_q <= 1'b0;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sda_pull_q <= ~shift_q[6];
              end
            end
          end
          ST_MACK: begin
            // controller ack continues the read, a nack waits for stop
            if (scl_rise && !sda_s2_q) bit_cnt_q <= BIT_CNT_RST;
            else if (scl_fall && bit_cnt_q == BIT_CNT_RST) begin
              st_q <= ST_SEND;
              shift_q <= tx_data_in;
              sda_pull_q <= ~tx_data_in[7];
              txreq_q <= 1'b1;
            end
          end
          default: sda_pull_q <= 1'b0;
        endcase
      end
    end
  end

  // overflow is sticky; a word lost to a full fifo is not acknowledged
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) ovf_q <= 1'b0;
    else if (clk_en_in && push_q && !fifo_ready) ovf_q <= 1'b1;
  end

  seepb_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .wr_valid_in(push_q),
    .wr_ready_out(fifo_ready),
    .wr_data_in(push_data_q),
    .rd_valid_out(rx_valid_out),
    .rd_ready_in(rx_ready_in),
    .rd_data_out(rx_data_out)
  );

  // open drain: output value always low, enable low while pulling
  assign bus.sda_out_dev = 1'b0;
  assign bus.sda_oe_n_dev = ~sda_pull_q;
  assign standby_out = standby_q;
  assign busy_out = busy_q;
  assign read_mode_out = read_q;
  assign start_out = start_q;
  assign stop_out = stop_q;
  assign tx_req_out = txreq_q;
  assign overflow_out = ovf_q;
endmodule : seepb_dev

// *** rtl/seepb_host.sv ***
// seepb_host: two-wire bus controller, one bus command at a time
// assumes sda from the bus is asynchronous; scl is made here by a divider

module seepb_host (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // bus pins
  seepb_if.host bus,
  // command port
  input wire logic cmd_valid_in,
  input wire seepb_pkg::seepb_cmd_t cmd_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  // answer
  output logic done_out,
  output logic [7:0] rd_data_out,
  output logic ack_out
);
  import seepb_pkg::*;
  typedef enum logic [2:0] {
    HS_IDLE, HS_LOW, HS_HIGH, HS_DONE
  } seepb_host_st_t;

  seepb_host_st_t st_q;
  seepb_cmd_t cmd_q;
  logic [7:0] div_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic scl_q, sda_q, sda_s1_q, sda_s2_q;
  logic done_q, ack_q;
  logic [7:0] rd_q;
  wire tick = (div_q == HALF_SCL_CNT);
  wire mid = (div_q == QUART_SCL_CNT);
  wire is_rd = (cmd_q == SEEPB_CMD_READ_ACK) | (cmd_q == SEEPB_CMD_READ_NACK);
  wire last_bit = (cmd_q == SEEPB_CMD_RECOVER) ? (bit_q == RECOVER_CLOCKS - 1'b1) : (bit_q == ACK_BIT);

  // sda sampled through two flops
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else if (clk_en_in) begin
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // bit engine; sda only moves mid clock-low, except for start and stop
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= HS_IDLE;
      cmd_q <= SEEPB_CMD_START;
      div_q <= '0;
      bit_q <= BIT_CNT_RST;
      sh_q <= '1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= BYTE_RST;
    end else if (clk_en_in) begin
      done_q <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      case (st_q)
        HS_IDLE: begin
          div_q <= '0;
          if (cmd_valid_in) begin
            cmd_q <= cmd_in;
            bit_q <= BIT_CNT_RST;
            // data word then ack slot released; read-ack releases the word and drives ack last, others release all
            case (cmd_in)
              SEEPB_CMD_WRITE: sh_q <= {cmd_data_in, 1'b1};
              SEEPB_CMD_READ_ACK: sh_q <= 9'h1FE;
              default: sh_q <= 9'h1FF;
            endcase
            st_q <= (cmd_in == SEEPB_CMD_START || cmd_in == SEEPB_CMD_STOP) ? HS_HIGH : HS_LOW;
            if (cmd_in == SEEPB_CMD_STOP) sda_q <= 1'b0;
          end
        end
        HS_LOW: begin
          scl_q <= 1'b0;
          if (mid && cmd_q != SEEPB_CMD_RECOVER) sda_q <= sh_q[8];
          if (mid && cmd_q == SEEPB_CMD_RECOVER) sda_q <= 1'b1;
          if (tick) st_q <= HS_HIGH;
        end
        HS_HIGH: begin
          scl_q <= 1'b1;
          if (cmd_q == SEEPB_CMD_START && mid) sda_q <= 1'b0;
          else if (cmd_q == SEEPB_CMD_STOP && mid) sda_q <= 1'b1;
          if (tick) begin
            if (cmd_q == SEEPB_CMD_START || cmd_q == SEEPB_CMD_STOP) begin
              st_q <= HS_DONE;
            end else begin
              if (is_rd && bit_q < ACK_BIT) rd_q <= {rd_q[6:0], sda_s2_q};
              if (bit_q == ACK_BIT) ack_q <= ~sda_s2_q;
              sh_q <= {sh_q[7:0], 1'b1};
              bit_q <= bit_q + 1'b1;
              // recovery ends early once sda is seen high
              if (last_bit || (cmd_q == SEEPB_CMD_RECOVER && sda_s2_q)) st_q <= HS_DONE;
              else st_q <= HS_LOW;
            end
          end
        end
        default: begin
          // start leaves scl low so data may follow
          if (cmd_q != SEEPB_CMD_STOP && cmd_q != SEEPB_CMD_RECOVER) scl_q <= 1'b0;
          if (tick) begin
            st_q <= HS_IDLE;
            done_q <= 1'b1;
          end
        end
      endcase
    end
  end

  assign bus.scl_out_host = 1'b0;
  assign bus.scl_oe_n_host = scl_q;
  assign bus.sda_out_host = 1'b0;
  assign bus.sda_oe_n_host = sda_q;
  assign cmd_ready_out = (st_q == HS_IDLE);
  assign done_out = done_q;
  assign rd_data_out = rd_q;
  assign ack_out = ack_q;
endmodule : seepb_host

// *** dv/seepb_assertions.sv ***
// seepb_assertions: protocol checks on the shared two-wire bus
// assumes one system clock; the bench instantiates it beside the interface
module seepb_assertions #(
  parameter int unsigned PROG_CYCLES_P = 50
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // bus wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_out_dev,
  input wire logic sda_oe_n_dev,
  // device status
  input wire logic start_out,
  input wire logic stop_out,
  input wire logic busy_out,
  input wire logic standby_out,
  input wire logic read_mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] busy_cnt_q;
  logic [17:0] busy_cnt_d;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // busy length count, too long for a repetition
  assign busy_cnt_d = busy_out ? busy_cnt_q + 18'h00001 : 18'h00000;
  always_ff @(posedge clk_sys_in) begin
    busy_cnt_q <= sys_rst_in ? 18'h00000 : busy_cnt_d;
  end
  a_dev_pull_only: assert property (!sda_oe_n_dev |-> !sda_out_dev)
    else $error("device drove sda high");
  a_dev_change_low: assert property ($changed(sda_oe_n_dev) |-> !scl)
    else $error("device moved sda while scl high");
  a_start_seen: assert property ($fell(sda) && scl && !busy_out |-> ##[1:6] start_out)
    else $error("start not reported");
  a_stop_seen: assert property ($rose(sda) && scl && !busy_out |-> ##[1:6] stop_out)
    else $error("stop not reported");
  a_busy_no_ack: assert property (busy_out |-> sda_oe_n_dev)
    else $error("device drove sda during write cycle");
  a_busy_bounded: assert property (busy_cnt_q <= PROG_CYCLES_P)
    else $error("write cycle too long");
  a_standby_quiet: assert property (standby_out |-> !busy_out && sda_oe_n_dev)
    else $error("standby while active");
  a_read_stop_idle: assert property (stop_out && read_mode_out && !busy_out |-> ##[0:3] standby_out)
    else $error("no standby after read stop");
  // main scenarios reached
  c_start: cover property (start_out);
  c_write_cycle: cover property ($rose(busy_out));
  c_read: cover property (read_mode_out && stop_out);
endmodule : seepb_assertions

// *** dv/seepb_bench.sv ***
// seepb_bench: bus controller and eeprom target joined on one bus
// assumes a 25 MHz clock; the write cycle is shortened by a parameter
module seepb_bench import seepb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PROG_SIM = 3000;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  seepb_cmd_t cmd_in = SEEPB_CMD_START;
  logic [7:0] cmd_data_in = 8'h00;
  logic cmd_ready_out, done_out, ack_out, rx_valid_out;
  logic [7:0] rd_data_out;
  logic [7:0] rx_data_out;
  logic rx_ready_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic ack_en_in = 1'b1;
  logic standby_out, busy_out, read_mode_out, start_out, stop_out, tx_req_out, overflow_out;
  int err_count = 0;
  int tests_run = 0;
  int seed = 16;
  int n;
  int tx_reqs = 0;
  logic [7:0] b;
  logic [7:0] q[$];
  // 25 MHz system clock
  always #20 clk_sys_in = ~clk_sys_in;
  // count the device's requests for a byte to send
  always @(posedge clk_sys_in) begin
    if (tx_req_out === 1'b1) tx_reqs++;
  end
  seepb_if seepb_if_i ();
  seepb_host seepb_host_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .bus(seepb_if_i), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_data_in(cmd_data_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .rd_data_out(rd_data_out), .ack_out(ack_out));
  seepb_dev #(.PROG_CYCLES_P(PROG_SIM)) seepb_dev_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(1'b1), .bus(seepb_if_i), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
    .rx_ready_in(rx_ready_in), .tx_data_in(tx_data_in), .ack_en_in(ack_en_in),
    .standby_out(standby_out), .busy_out(busy_out), .read_mode_out(read_mode_out),
    .start_out(start_out), .stop_out(stop_out), .tx_req_out(tx_req_out), .overflow_out(overflow_out));
  seepb_assertions #(.PROG_CYCLES_P(PROG_SIM)) seepb_assertions_i (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .scl(seepb_if_i.scl), .sda(seepb_if_i.sda),
    .sda_out_dev(seepb_if_i.sda_out_dev), .sda_oe_n_dev(seepb_if_i.sda_oe_n_dev),
    .start_out(start_out), .stop_out(stop_out), .busy_out(busy_out), .standby_out(standby_out),
    .read_mode_out(read_mode_out));

  // verdict, the only place the run ends
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // one compare for all results, bits widened to a byte
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic give_up(input string what);
    err_count++;
    $display("CHECK FAILED %s expected finish seen timeout", what);
    tally_and_finish();
  endtask : give_up

  // one host command: held from a falling edge across the taking edge
  task automatic cmd(input seepb_cmd_t c, input logic [7:0] d);
    int i;
    @(negedge clk_sys_in);
    for (i = 0; i < 300 && cmd_ready_out !== 1'b1; i++) @(negedge clk_sys_in);
    if (i == 300) give_up("ready");
    cmd_valid_in = 1'b1;
    cmd_in = c;
    cmd_data_in = d;
    @(negedge clk_sys_in);
    cmd_valid_in = 1'b0;
    for (i = 0; i < 5000 && done_out !== 1'b1; i++) @(negedge clk_sys_in);
    if (i == 5000) give_up("command");
  endtask : cmd

  // write cycle may still run; standby follows its end
  task automatic wait_standby();
    int i;
    for (i = 0; i < PROG_SIM + 500 && standby_out !== 1'b1; i++) @(negedge clk_sys_in);
    check("standby", 8'h01, {7'h00, standby_out});
    check("busy", 8'h00, {7'h00, busy_out});
  endtask : wait_standby

  initial begin
    repeat (5) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    check("standby at reset", 8'h01, {7'h00, standby_out});
    // fill the fifo with the far side stalled until a word is refused
    cmd(SEEPB_CMD_START, 8'h00);
    for (n = 0; n < 18; n++) begin
      b = 8'($random(seed));
      if (n == 0) b[0] = 1'b0;
      cmd(SEEPB_CMD_WRITE, b);
      if (ack_out !== 1'b1) break;
      q.push_back(b);
    end
    check("acked words", 8'h10, 8'(q.size()));
    check("overflow", 8'h01, {7'h00, overflow_out});
    check("write select", 8'h00, {7'h00, read_mode_out});
    // drain in order, one pop per cycle
    for (n = 0; n < 100 && q.size() > 0; n++) begin
      @(negedge clk_sys_in);
      if (rx_valid_out === 1'b1) check("rx word", q.pop_front(), rx_data_out);
      rx_ready_in = (rx_valid_out === 1'b1);
    end
    @(negedge clk_sys_in);
    check("fifo empty", 8'h00, {7'h00, rx_valid_out});
    $display("fill and drain test done");
    // write cycle, traffic meanwhile must go unanswered
    cmd(SEEPB_CMD_STOP, 8'h00);
    check("busy after stop", 8'h01, {7'h00, busy_out});
    cmd(SEEPB_CMD_START, 8'h00);
    cmd(SEEPB_CMD_WRITE, 8'($random(seed)) & 8'hFE);
    check("ack while busy", 8'h00, {7'h00, ack_out});
    cmd(SEEPB_CMD_STOP, 8'h00);
    wait_standby();
    $display("write cycle test done");
    // read of two words, the second not acked by the controller
    tx_data_in = 8'($random(seed));
    cmd(SEEPB_CMD_START, 8'h00);
    cmd(SEEPB_CMD_WRITE, 8'($random(seed)) | 8'h01);
    check("read address ack", 8'h01, {7'h00, ack_out});
    check("read select", 8'h01, {7'h00, read_mode_out});
    // first word is loaded already; the next one loads as this ack clock ends
    b = tx_data_in;
    tx_data_in = 8'($random(seed));
    cmd(SEEPB_CMD_READ_ACK, 8'h00);
    check("read word", b, rd_data_out);
    b = tx_data_in;
    cmd(SEEPB_CMD_READ_NACK, 8'h00);
    check("last read word", b, rd_data_out);
    cmd(SEEPB_CMD_STOP, 8'h00);
    wait_standby();
    check("tx requests", 8'h02, 8'(tx_reqs));
    $display("read test done");
    // recovery clock lands mid-word, a start reframes, then a word refused by the ack enable
    cmd(SEEPB_CMD_START, 8'h00);
    cmd(SEEPB_CMD_WRITE, 8'($random(seed)) & 8'hFE);
    cmd(SEEPB_CMD_RECOVER, 8'h00);
    cmd(SEEPB_CMD_START, 8'h00);
    cmd(SEEPB_CMD_WRITE, 8'($random(seed)) & 8'hFE);
    check("ack after recovery", 8'h01, {7'h00, ack_out});
    ack_en_in = 1'b0;
    cmd(SEEPB_CMD_WRITE, 8'($random(seed)));
    check("ack disabled", 8'h00, {7'h00, ack_out});
    ack_en_in = 1'b1;
    cmd(SEEPB_CMD_STOP, 8'h00);
    wait_standby();
    $display("recovery test done");
    tally_and_finish();
  end
endmodule : seepb_bench
